// *** verilog/rbd_pkg.sv ***
// Notes on behaviour
// - rotate right: bit 0 goes to bit 7 and carry; two clocks
// - rotate left: bit 7 goes to bit 0 and carry; two clocks
// - rotate right through carry as a nine-bit rotation
// - rotate left through carry as a nine-bit rotation
// - nibble rotate right between accumulator low nibble and pointed byte
// - nibble rotate left between accumulator low nibble and pointed byte
// - decimal fix after add or subtract sets zero, aux carry, carry; four clocks
// - short count for fast RAM or no data access, long count otherwise; accumulator bit ops also take the long count when slow_area is set
// - each read wait adds one clock to the long count
// - each write wait adds one clock to the long count of a writing op
// - one instruction clock is one cpu clock period; counts for internal ROM
package rbd_pkg;
  typedef enum logic [3:0] {
    RBD_ROR, RBD_ROL, RBD_ROTATE_RIGHT_THRU_CARRY, RBD_ROTATE_LEFT_THRU_CARRY, RBD_NRR, RBD_NRL,
    RBD_DAA, RBD_DAS, RBD_BIT_TO_CY, RBD_CY_TO_BIT
  } rbd_op_t;

  typedef struct packed {
    rbd_op_t op;
    logic [7:0] acc;
    logic [7:0] mem;
    logic [7:0] program_status_word;
    logic [2:0] bit_sel;
    logic slow_area;
    logic mem_src;
  } rbd_req_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] mem;
    logic [7:0] program_status_word;
    logic mem_we;
    logic [5:0] clocks;
  } rbd_res_t;

  localparam int RBD_PSW_CY = 0;
  localparam int RBD_PSW_AC = 4;
  localparam int RBD_PSW_Z = 6;
  localparam logic [5:0] RBD_CLK_ROT = 6'h02;
  localparam logic [5:0] RBD_CLK_NIB_FAST = 6'h0A;
  localparam logic [5:0] RBD_CLK_NIB_SLOW = 6'h0C;
  localparam logic [5:0] RBD_CLK_DEC = 6'h04;
  localparam logic [5:0] RBD_CLK_BIT_RD_FAST = 6'h04;
  localparam logic [5:0] RBD_CLK_BIT_RD_SLOW = 6'h07;
  localparam logic [5:0] RBD_CLK_BIT_WR_FAST = 6'h04;
  localparam logic [5:0] RBD_CLK_BIT_WR_SLOW = 6'h08;
  localparam logic [7:0] RBD_RESET_BYTE = 8'h00;
  localparam logic [5:0] RBD_RESET_CLK = 6'h00;
endpackage

// *** verilog/rbd_datapath.sv ***
`timescale 1ns/1ps
module rbd_datapath
  import rbd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // request
  input wire logic start_in,
  input wire rbd_req_t req_in,
  input wire logic [3:0] read_waits_in,
  input wire logic [3:0] write_waits_in,
  // result
  output logic done_out,
  output rbd_res_t res_out
);
  wire logic [7:0] a = req_in.acc;
  wire logic [7:0] m = req_in.mem;
  wire logic cy = req_in.program_status_word[RBD_PSW_CY];
  wire logic ac = req_in.program_status_word[RBD_PSW_AC];
  wire logic [5:0] rw = {2'h0, read_waits_in};
  wire logic [5:0] ww = {2'h0, write_waits_in};
  wire logic slow = req_in.slow_area;

  wire logic [7:0] ror_a = {a[0], a[7:1]};
  wire logic [7:0] rol_a = {a[6:0], a[7]};
  wire logic [7:0] rotate_right_thru_carry_a = {cy, a[7:1]};
  wire logic [7:0] rotate_left_thru_carry_a = {a[6:0], cy};
  wire logic [7:0] nrr_a = {a[7:4], m[3:0]};
  wire logic [7:0] nrr_m = {a[3:0], m[7:4]};
  wire logic [7:0] nrl_a = {a[7:4], m[7:4]};
  wire logic [7:0] nrl_m = {m[3:0], a[3:0]};

  wire logic lo_fix_add = ac || (a[3:0] > 4'h9);
  wire logic hi_fix_add = cy || (a > 8'h99);
  wire logic [7:0] add_fix = {hi_fix_add ? 4'h6 : 4'h0, lo_fix_add ? 4'h6 : 4'h0};
  wire logic [8:0] daa_sum = {1'b0, a} + {1'b0, add_fix};
  wire logic [7:0] daa_a = daa_sum[7:0];
  wire logic daa_cy = hi_fix_add;
  wire logic daa_ac = (a[3:0] + (lo_fix_add ? 4'h6 : 4'h0)) < a[3:0];
  wire logic [7:0] add_fix_sub = {cy ? 4'h6 : 4'h0, ac ? 4'h6 : 4'h0};
  wire logic [7:0] das_a = a - add_fix_sub;
  wire logic das_ac = ac && (a[3:0] < 4'h6);
  wire logic das_cy = cy;

  wire logic [7:0] bit_src = req_in.mem_src ? m : a;
  wire logic sel_bit = bit_src[req_in.bit_sel];
  wire logic [7:0] bit_mask = 8'h01 << req_in.bit_sel;
  wire logic [7:0] bit_wr = cy ? (bit_src | bit_mask) : (bit_src & ~bit_mask);

  wire logic [5:0] nib_clk = slow ? (RBD_CLK_NIB_SLOW + rw + ww) : RBD_CLK_NIB_FAST;
  wire logic [5:0] brd_clk = slow ? (RBD_CLK_BIT_RD_SLOW + rw) : RBD_CLK_BIT_RD_FAST;
  wire logic [5:0] bwr_clk = slow ? (RBD_CLK_BIT_WR_SLOW + rw + ww) : RBD_CLK_BIT_WR_FAST;

  rbd_res_t next_res;
  logic [7:0] next_psw;

  always_comb begin
    next_psw = req_in.program_status_word;
    next_res = '{acc: a, mem: m, program_status_word: req_in.program_status_word, mem_we: 1'b0, clocks: RBD_CLK_ROT};
    case (req_in.op)
      RBD_ROR: begin
        next_res.acc = ror_a;
        next_psw[RBD_PSW_CY] = a[0];
      end
      RBD_ROL: begin
        next_res.acc = rol_a;
        next_psw[RBD_PSW_CY] = a[7];
      end
      RBD_ROTATE_RIGHT_THRU_CARRY: begin
        next_res.acc = rotate_right_thru_carry_a;
        next_psw[RBD_PSW_CY] = a[0];
      end
      RBD_ROTATE_LEFT_THRU_CARRY: begin
        next_res.acc = rotate_left_thru_carry_a;
        next_psw[RBD_PSW_CY] = a[7];
      end
      RBD_NRR: begin
        next_res.acc = nrr_a;
        next_res.mem = nrr_m;
        next_res.mem_we = 1'b1;
        next_res.clocks = nib_clk;
      end
      RBD_NRL: begin
        next_res.acc = nrl_a;
        next_res.mem = nrl_m;
        next_res.mem_we = 1'b1;
        next_res.clocks = nib_clk;
      end
      RBD_DAA: begin
        next_res.acc = daa_a;
        next_psw[RBD_PSW_Z] = (daa_a == 8'h00);
        next_psw[RBD_PSW_AC] = daa_ac;
        next_psw[RBD_PSW_CY] = daa_cy;
        next_res.clocks = RBD_CLK_DEC;
      end
      RBD_DAS: begin
        next_res.acc = das_a;
        next_psw[RBD_PSW_Z] = (das_a == 8'h00);
        next_psw[RBD_PSW_AC] = das_ac;
        next_psw[RBD_PSW_CY] = das_cy;
        next_res.clocks = RBD_CLK_DEC;
      end
      RBD_BIT_TO_CY: begin
        next_psw[RBD_PSW_CY] = sel_bit;
        next_res.clocks = brd_clk;
      end
      RBD_CY_TO_BIT: begin
        if (req_in.mem_src) begin
          next_res.mem = bit_wr;
          next_res.mem_we = 1'b1;
        end else begin
          next_res.acc = bit_wr;
        end
        next_res.clocks = bwr_clk;
      end
      default: begin
        next_res.clocks = RBD_CLK_ROT;
      end
    endcase
    next_res.program_status_word = next_psw;
  end

  // one cpu clock per instruction clock
  logic [5:0] count;
  rbd_res_t held;
  wire logic busy = (count != RBD_RESET_CLK);
  wire logic last = (count == 6'h01);

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      count <= RBD_RESET_CLK;
      held <= '{acc: RBD_RESET_BYTE, mem: RBD_RESET_BYTE, program_status_word: RBD_RESET_BYTE,
                mem_we: 1'b0, clocks: RBD_RESET_CLK};
      done_out <= 1'b0;
      res_out <= '{acc: RBD_RESET_BYTE, mem: RBD_RESET_BYTE, program_status_word: RBD_RESET_BYTE,
                   mem_we: 1'b0, clocks: RBD_RESET_CLK};
    end else begin
      done_out <= busy && last;
      if (busy && last) begin
        res_out <= held;
      end
      if (start_in && !busy) begin
        held <= next_res;
        count <= next_res.clocks - 6'h01;
        if (next_res.clocks == 6'h01) begin
          count <= RBD_RESET_CLK;
        end
      end else if (busy) begin
        count <= count - 6'h01;
      end
    end
  end
endmodule

// *** testbench/rbd_datapath_sva.sv ***
`timescale 1ns/1ps
module rbd_datapath_sva
  import rbd_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire rbd_req_t req_in,
  input wire logic [3:0] read_waits_in,
  input wire logic [3:0] write_waits_in,
  input wire logic done_out,
  input wire rbd_res_t res_out
);
  logic idle;
  rbd_req_t q;
  logic [5:0] w;
  // idle again in the done cycle, so a start there is taken
  wire tk = start_in && (idle || done_out);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  always_ff @(posedge sys_clk_in) begin
    idle <= !resetn_in || ((idle || done_out) && !start_in);
    if (tk) begin
      q <= req_in;
      w <= 6'h0C + 6'(read_waits_in) + 6'(write_waits_in);
    end
  end
  a_ror_res:
    assert property (tk && req_in.op == RBD_ROR |-> ##2 done_out && res_out.acc ==
      {q.acc[0], q.acc[7:1]} && res_out.program_status_word[RBD_PSW_CY] == q.acc[0]) else $error("ror bad");
  a_rol_res:
    assert property (tk && req_in.op == RBD_ROL |-> ##2 done_out && res_out.acc ==
      {q.acc[6:0], q.acc[7]} && res_out.program_status_word[RBD_PSW_CY] == q.acc[7]) else $error("rol bad");
  a_rotate_right_thru_carry_res:
    assert property (tk && req_in.op == RBD_ROTATE_RIGHT_THRU_CARRY |-> ##2 done_out && {res_out.acc,
      res_out.program_status_word[RBD_PSW_CY]} == {q.program_status_word[RBD_PSW_CY], q.acc}) else $error("rotate_right_thru_carry bad");
  a_rotate_left_thru_carry_res:
    assert property (tk && req_in.op == RBD_ROTATE_LEFT_THRU_CARRY |-> ##2 done_out && {res_out.program_status_word[RBD_PSW_CY],
      res_out.acc} == {q.acc, q.program_status_word[RBD_PSW_CY]}) else $error("rotate_left_thru_carry bad");
  a_nib_fast:
    assert property (tk && req_in.op == RBD_NRR && !req_in.slow_area |-> ##10 done_out &&
      res_out.mem == {q.acc[3:0], q.mem[7:4]}) else $error("nibble fast bad");
  a_nib_slow:
    assert property (tk && req_in.op == RBD_NRL && req_in.slow_area |-> ##[12:42] done_out &&
      res_out.clocks == w && res_out.mem == {q.mem[3:0], q.acc[3:0]}) else $error("slow bad");
  a_dec_four:
    assert property (tk && req_in.op inside {RBD_DAA, RBD_DAS} |=> !done_out[*3] ##1 done_out)
      else $error("decimal count bad");
  a_done_pulse:
    assert property (done_out |=> !done_out) else $error("done not a pulse");
endmodule
bind rbd_datapath rbd_datapath_sva u_sva (.sys_clk_in, .resetn_in, .start_in, .req_in,
  .read_waits_in, .write_waits_in, .done_out, .res_out);

// *** testbench/rotate_bcd_bit_datapath_tb.sv ***
`timescale 1ns/1ps
module rotate_bcd_bit_datapath_tb;
  import rbd_pkg::*;
  logic sys_clk_in = 0, resetn_in = 0, start_in = 0, done_out;
  logic [3:0] read_waits_in = 0, write_waits_in = 0;
  rbd_req_t req_in = '0, r;
  rbd_res_t res_out;
  int fails = 0, checks = 0, seed = 59835, cyc = 0, i;
  always #5 sys_clk_in = ~sys_clk_in;
  rbd_datapath DUT (.sys_clk_in, .resetn_in, .start_in, .req_in, .read_waits_in,
    .write_waits_in, .done_out, .res_out);
  always @(posedge sys_clk_in) if (++cyc > 30000) begin
    fails++;
    finish_test();
  end
  task finish_test();
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  function automatic rbd_res_t ex(rbd_req_t r, logic [3:0] n, m);
    logic [7:0] a = r.acc, b = r.mem;
    logic c = r.program_status_word[0], h = r.program_status_word[4], hi = r.program_status_word[0] || r.acc > 8'h99;
    ex = '0;
    ex.mem = b;
    ex.program_status_word = r.program_status_word;
    ex.clocks = 6'h02;
    case (r.op)
      RBD_ROR: {a, c} = {r.acc[0], r.acc[7:1], r.acc[0]};
      RBD_ROL: {c, a} = {r.acc[7], r.acc[6:0], r.acc[7]};
      RBD_ROTATE_RIGHT_THRU_CARRY: {a, c} = {c, r.acc};
      RBD_ROTATE_LEFT_THRU_CARRY: {c, a} = {r.acc, c};
      RBD_NRR, RBD_NRL: begin
        a[3:0] = r.op == RBD_NRR ? b[3:0] : b[7:4];
        ex.mem = r.op == RBD_NRR ? {r.acc[3:0], b[7:4]} : {b[3:0], r.acc[3:0]};
        ex.clocks = r.slow_area ? 6'h0C + 6'(n) + 6'(m) : 6'h0A;
      end
      RBD_DAA: begin
        if (h || a[3:0] > 4'h9) a += 8'h06;
        if (hi) a += 8'h60;
        c = hi;
        ex.clocks = 6'h04;
      end
      RBD_DAS: begin
        a -= (h ? 8'h06 : 8'h00) + (c ? 8'h60 : 8'h00);
        ex.clocks = 6'h04;
      end
      RBD_BIT_TO_CY: begin
        c = r.mem_src ? b[r.bit_sel] : a[r.bit_sel];
        ex.clocks = r.slow_area ? 6'h07 + 6'(n) : 6'h04;
      end
      default: begin
        if (r.mem_src) ex.mem[r.bit_sel] = c;
        else a[r.bit_sel] = c;
        ex.clocks = r.slow_area ? 6'h08 + 6'(n) + 6'(m) : 6'h04;
      end
    endcase
    ex.acc = a;
    ex.program_status_word[0] = c;
  endfunction
  task run(input rbd_req_t r, input logic [3:0] n, m);
    rbd_res_t e;
    int k;
    e = ex(r, n, m);
    start_in <= 1;
    req_in <= r;
    read_waits_in <= n;
    write_waits_in <= m;
    @(posedge sys_clk_in);
    start_in <= 0;
    k = 1;
    do begin
      @(posedge sys_clk_in);
      #1 k++;
    end while (done_out !== 1'b1 && k < 60);
    chk(8'(k), 8'(e.clocks)); // cycles
    chk(8'(res_out.clocks), 8'(e.clocks)); // count
    chk(res_out.acc, e.acc); // acc
    chk(8'(res_out.program_status_word[0]), 8'(e.program_status_word[0])); // carry
    if (r.op inside {RBD_NRR, RBD_NRL, RBD_CY_TO_BIT}) chk(res_out.mem, e.mem); // byte
    chk(8'(res_out.mem_we), 8'(r.op inside {RBD_NRR, RBD_NRL} || (r.op == RBD_CY_TO_BIT && r.mem_src)));
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_in);
    resetn_in <= 1;
    @(posedge sys_clk_in);
    #1 r = '0;
    r.acc = 8'h9A;
    r.slow_area = 1;
    for (i = 0; i < 10; i++) begin
      r.op = rbd_op_t'(i);
      run(r, 4'hF, 4'hF);
    end
    for (i = 0; i < 400; i++) begin
      r = 33'($random(seed));
      r.op = rbd_op_t'(i % 10);
      run(r, 4'($random(seed)), 4'($random(seed)));
    end
    finish_test();
  end
endmodule
